// [logic/bvc_defines.svh]
// Purpose: register offsets, field positions and reset values of the bank
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   definitions only; included by bare name
`ifndef BVC_DEFINES_SVH
`define BVC_DEFINES_SVH

// register byte offsets
`define BVC_OFF_ACK      8'hb0
`define BVC_OFF_DRV      8'hb4
`define BVC_OFF_PM       8'hb8
`define BVC_OFF_TEST1    8'hbc
`define BVC_OFF_TEST2    8'hc0
`define BVC_OFF_TEST3    8'hc4
`define BVC_OFF_STRAP    8'hc8
`define BVC_OFF_GPIO     8'hd8
`define BVC_OFF_EE       8'hdc
`define BVC_OFF_CAP      8'he0

// acknowledge latency fields
`define BVC_ACK_LSB      16
`define BVC_ACK_MSB      29
`define BVC_ACK_EN_BIT   30
`define BVC_ACK_RST      14'h0000

// serial driver select fields
`define BVC_CH0_LSB      0
`define BVC_CH0_MSB      3
`define BVC_CH1_LSB      4
`define BVC_CH1_MSB      7
`define BVC_DRV_RST      32'h0000_0000
`define BVC_MODE_RS232   4'h0
`define BVC_MODE_RS422   4'h1
`define BVC_MODE_RS485_4 4'hb
`define BVC_MODE_RS485_2 4'hf

// power management parameter
`define BVC_PM_MSB       5

// strap status fields
`define BVC_STRAP_MSB    13

// general pin control fields
`define BVC_GIN_LSB      0
`define BVC_GIN_MSB      7
`define BVC_GDIR_LSB     8
`define BVC_GDIR_MSB     15
`define BVC_GOUT_LSB     16
`define BVC_GOUT_MSB     23

// eeprom command fields
`define BVC_EE_START_BIT 0
`define BVC_EE_PRE_BIT   2
`define BVC_EE_CMD_LSB   3
`define BVC_EE_CMD_MSB   4
`define BVC_EE_ADR_LSB   5
`define BVC_EE_ADR_MSB   15
`define BVC_EE_DAT_LSB   16
`define BVC_EE_DAT_MSB   31

// link capability header values
`define BVC_CAP_ID       8'h10
`define BVC_CAP_NEXT     8'h00
`define BVC_CAP_VER      4'h1
`define BVC_CAP_TYPE     4'h1
`define BVC_CAP_SLOT     1'b0
`define BVC_CAP_MSGNUM   5'h00
`define BVC_CAP_RSV      2'h0

`define BVC_ZERO32       32'h0000_0000

`endif

// [logic/bvc_pkg.sv]
// Purpose: types of the vendor configuration bank
// Assumes: nothing beyond the defines header
// Notes:   state of the bank is one packed struct
`default_nettype none
package bvc_pkg;
  typedef enum logic [1:0] {
    BVC_CMD_RSV0  = 2'b00,
    BVC_CMD_WRITE = 2'b01,
    BVC_CMD_READ  = 2'b10,
    BVC_CMD_RSV3  = 2'b11
  } bvc_ee_cmd_t;

  typedef enum logic {
    BVC_EE_IDLE = 1'b0,
    BVC_EE_BUSY = 1'b1
  } bvc_ee_fsm_t;

  typedef struct packed {
    logic [13:0] ack_user;
    logic        ack_en;
    logic [13:0] ack_eff;
    logic [31:0] drv_sel;
    logic [5:0]  pm_param;
    logic [13:0] strap_s1;
    logic [13:0] strap_s2;
    logic [13:0] strap;
    logic        strap_locked;
    logic [7:0]  gpio_s1;
    logic [7:0]  gpio_s2;
    logic [7:0]  gpio_dir;
    logic [7:0]  gpio_dout;
    logic        ee_start;
    logic        ee_preload;
    bvc_ee_cmd_t ee_cmd;
    logic [10:0] ee_addr;
    logic [15:0] ee_data;
    bvc_ee_fsm_t ee_fsm;
    logic        ee_req;
    logic        ee_write;
    logic [31:0] rdata;
  } bvc_state_t;
endpackage : bvc_pkg
`default_nettype wire

// [logic/bvc_regs.sv]
// Purpose: vendor configuration register bank of the serial-port bridge
// Assumes: one 125 MHz clock, synchronous active-high reset,
//          autoload writes come from the eeprom loader on the same clock
// Notes:   reads answer one cycle after the read strobe, unmapped read 0
//
// Summary of operation
// R01: 14-bit user ack latency in bits 29:16, reset zero, autoloadable, RW.
// R02: bit 30 set selects user ack latency over built-in default.
// R03: channel 0 driver mode in bits 3:0, reset RS232.
// R04: channel 1 driver mode in bits 7:4, same codes, reset RS232.
// R05: three read-only test registers always read zero.
// R06: low and high drive straps in strap status bits 0 and 1.
// R07: tx current straps bits 5:2, tx de-emphasis straps bits 9:6.
// R08: rx termination bits 11:10, tx termination 13:12, upper bits zero.
// R09: pin control bits 7:0 read live general pin levels.
// R10: bit x+8 sets pin x direction, one means output.
// R11: pin x driven from bit x+16 only while configured as output.
// R12: software sets start bit 0 to launch an eeprom cycle.
// R13: command 01 write, 10 read; 00 and 11 reserved, never issued.
// R14: eeprom word address bits 15:5, write data bits 31:16, reset zero.
// R15: capability id byte reads 10h.
// R16: next-capability pointer reads 00h.
// R17: capability version reads 0001b.
// R18: device type field reads 1h, legacy endpoint.
// R19: slot bit and interrupt message number read zero.
// R20: start bit clears when the eeprom operation completes.
`default_nettype none
`include "bvc_defines.svh"

module bvc_regs #(
  parameter logic [13:0] ACK_DEFAULT = 14'h0000,
  parameter logic [5:0]  PM_RESET    = 6'h00
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // eeprom autoload writes
  input  wire logic        i_al_wr,
  input  wire logic [7:0]  i_al_addr,
  input  wire logic [31:0] i_al_data,
  // strap pins
  input  wire logic        i_low_drive_strap,
  input  wire logic        i_high_drive_strap,
  input  wire logic [3:0]  i_tx_current_straps,
  input  wire logic [3:0]  i_tx_deemphasis_straps,
  input  wire logic [1:0]  i_rx_termination_straps,
  input  wire logic [1:0]  i_tx_termination_straps,
  // general purpose pins
  input  wire logic [7:0]  i_gpio_in,
  output logic      [7:0]  o_gpio_out,
  output logic      [7:0]  o_gpio_oe,
  // eeprom engine
  output logic             o_ee_req,
  output logic             o_ee_write,
  output logic      [10:0] o_ee_addr,
  output logic      [15:0] o_ee_wdata,
  input  wire logic        i_ee_done,
  input  wire logic [15:0] i_ee_rdata,
  output logic             o_ee_preload,
  // settings to the bridge core
  output logic      [13:0] o_ack_latency,
  output logic      [3:0]  o_ch0_mode,
  output logic      [3:0]  o_ch1_mode,
  output logic      [5:0]  o_pm_param
);

  bvc_pkg::bvc_state_t st;
  bvc_pkg::bvc_state_t next_st;
  logic [13:0]         strap_pins;
  logic [31:0]         cap_word;
  logic                sw_ee_wr;
  logic                ee_launch;
  logic                ee_refuse;

  // strap pins packed in status register order
  assign strap_pins = {i_tx_termination_straps, i_rx_termination_straps,
                       i_tx_deemphasis_straps, i_tx_current_straps,
                       i_high_drive_strap, i_low_drive_strap};

  // fixed capability header, nothing here is writable
  assign cap_word = {`BVC_CAP_RSV, `BVC_CAP_MSGNUM, `BVC_CAP_SLOT,
                     `BVC_CAP_TYPE, `BVC_CAP_VER,
                     `BVC_CAP_NEXT, `BVC_CAP_ID};

  // software write to the eeprom command register this cycle
  assign sw_ee_wr  = i_wr && (i_addr == `BVC_OFF_EE);
  assign ee_launch = (st.ee_fsm == bvc_pkg::BVC_EE_IDLE) && st.ee_start &&
                     ((st.ee_cmd == bvc_pkg::BVC_CMD_WRITE) ||
                      (st.ee_cmd == bvc_pkg::BVC_CMD_READ));
  assign ee_refuse = (st.ee_fsm == bvc_pkg::BVC_EE_IDLE) && st.ee_start &&
                     !ee_launch;

  // next-state logic of the whole bank
  always_comb begin
    next_st = st;
    // two-flop synchronisers; first stage feeds only the second
    next_st.strap_s1 = strap_pins;
    next_st.strap_s2 = st.strap_s1;
    next_st.gpio_s1  = i_gpio_in;
    next_st.gpio_s2  = st.gpio_s1;
    // straps track the pins until autoload overrides them
    if (!st.strap_locked) begin
      next_st.strap = st.strap_s2; // R06 R07 R08
    end

    // software writes to the writable registers
    if (i_wr) begin
      case (i_addr)
        `BVC_OFF_ACK: begin
          next_st.ack_user = i_wdata[`BVC_ACK_MSB:`BVC_ACK_LSB]; // R01
          next_st.ack_en   = i_wdata[`BVC_ACK_EN_BIT]; // R02
        end
        `BVC_OFF_DRV: begin
          next_st.drv_sel = i_wdata; // R03 R04
        end
        `BVC_OFF_PM: begin
          next_st.pm_param = i_wdata[`BVC_PM_MSB:0];
        end
        `BVC_OFF_GPIO: begin
          next_st.gpio_dir  = i_wdata[`BVC_GDIR_MSB:`BVC_GDIR_LSB]; // R10
          next_st.gpio_dout = i_wdata[`BVC_GOUT_MSB:`BVC_GOUT_LSB]; // R11
        end
        `BVC_OFF_EE: begin
          next_st.ee_preload = i_wdata[`BVC_EE_PRE_BIT];
          next_st.ee_cmd     = bvc_pkg::bvc_ee_cmd_t'(
                                 i_wdata[`BVC_EE_CMD_MSB:`BVC_EE_CMD_LSB]);
          next_st.ee_addr    = i_wdata[`BVC_EE_ADR_MSB:`BVC_EE_ADR_LSB]; // R14
          next_st.ee_data    = i_wdata[`BVC_EE_DAT_MSB:`BVC_EE_DAT_LSB]; // R14
        end
        default: begin
        end
      endcase
    end

    // autoload wins over a software write in the same cycle
    if (i_al_wr) begin
      case (i_al_addr)
        `BVC_OFF_ACK: begin
          next_st.ack_user = i_al_data[`BVC_ACK_MSB:`BVC_ACK_LSB]; // R01
          next_st.ack_en   = i_al_data[`BVC_ACK_EN_BIT];
        end
        `BVC_OFF_DRV: begin
          next_st.drv_sel = i_al_data; // R04
        end
        `BVC_OFF_PM: begin
          next_st.pm_param = i_al_data[`BVC_PM_MSB:0];
        end
        `BVC_OFF_STRAP: begin
          next_st.strap        = i_al_data[`BVC_STRAP_MSB:0]; // R06
          next_st.strap_locked = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // effective ack latency: user value only when enabled
    next_st.ack_eff = st.ack_en ? st.ack_user : ACK_DEFAULT; // R02

    // eeprom sequencer
    unique case (st.ee_fsm)
      bvc_pkg::BVC_EE_IDLE: begin
        if (ee_launch) begin
          next_st.ee_fsm   = bvc_pkg::BVC_EE_BUSY; // R12
          next_st.ee_req   = 1'b1;
          next_st.ee_write = (st.ee_cmd == bvc_pkg::BVC_CMD_WRITE); // R13
        end else if (ee_refuse) begin
          // reserved command: drop the request, never reach the engine
          next_st.ee_start = 1'b0; // R13
        end
      end
      bvc_pkg::BVC_EE_BUSY: begin
        if (i_ee_done) begin
          next_st.ee_fsm   = bvc_pkg::BVC_EE_IDLE;
          next_st.ee_req   = 1'b0;
          next_st.ee_start = 1'b0; // R20
          if (!st.ee_write) begin
            next_st.ee_data = i_ee_rdata;
          end
        end
      end
    endcase
    // a start written by software wins over the hardware clear
    if (sw_ee_wr && i_wdata[`BVC_EE_START_BIT]) begin
      next_st.ee_start = 1'b1; // R12
    end else if (sw_ee_wr) begin
      next_st.ee_start = 1'b0;
    end

    // read data stands for one cycle only
    next_st.rdata = `BVC_ZERO32;
    if (i_rd) begin
      case (i_addr)
        `BVC_OFF_ACK: begin
          next_st.rdata[`BVC_ACK_MSB:`BVC_ACK_LSB] = st.ack_user;
          next_st.rdata[`BVC_ACK_EN_BIT]          = st.ack_en;
        end
        `BVC_OFF_DRV: begin
          next_st.rdata = st.drv_sel;
        end
        `BVC_OFF_PM: begin
          next_st.rdata[`BVC_PM_MSB:0] = st.pm_param;
        end
        `BVC_OFF_TEST1, `BVC_OFF_TEST2, `BVC_OFF_TEST3: begin
          next_st.rdata = `BVC_ZERO32; // R05
        end
        `BVC_OFF_STRAP: begin
          next_st.rdata[`BVC_STRAP_MSB:0] = st.strap; // R08
        end
        `BVC_OFF_GPIO: begin
          next_st.rdata[`BVC_GIN_MSB:`BVC_GIN_LSB]   = st.gpio_s2; // R09
          next_st.rdata[`BVC_GDIR_MSB:`BVC_GDIR_LSB] = st.gpio_dir;
          next_st.rdata[`BVC_GOUT_MSB:`BVC_GOUT_LSB] = st.gpio_dout;
        end
        `BVC_OFF_EE: begin
          next_st.rdata[`BVC_EE_START_BIT] = st.ee_start;
          next_st.rdata[`BVC_EE_PRE_BIT]   = st.ee_preload;
          next_st.rdata[`BVC_EE_CMD_MSB:`BVC_EE_CMD_LSB] = st.ee_cmd;
          next_st.rdata[`BVC_EE_ADR_MSB:`BVC_EE_ADR_LSB] = st.ee_addr;
          next_st.rdata[`BVC_EE_DAT_MSB:`BVC_EE_DAT_LSB] = st.ee_data;
        end
        `BVC_OFF_CAP: begin
          next_st.rdata = cap_word; // R15 R16 R17 R18 R19
        end
        default: begin
        end
      endcase
    end
  end

  // single state register, synchronous reset to documented defaults
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st              <= '0;
      st.ack_user     <= `BVC_ACK_RST;
      st.ack_eff      <= ACK_DEFAULT;
      st.drv_sel      <= `BVC_DRV_RST;
      st.pm_param     <= PM_RESET;
      st.ee_cmd       <= bvc_pkg::BVC_CMD_RSV0;
      st.ee_fsm       <= bvc_pkg::BVC_EE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign o_rdata       = st.rdata;
  assign o_ack_latency = st.ack_eff;
  assign o_ch0_mode    = st.drv_sel[`BVC_CH0_MSB:`BVC_CH0_LSB]; // R03
  assign o_ch1_mode    = st.drv_sel[`BVC_CH1_MSB:`BVC_CH1_LSB]; // R04
  assign o_pm_param    = st.pm_param;
  assign o_gpio_oe     = st.gpio_dir; // R10
  assign o_gpio_out    = st.gpio_dout; // R11
  assign o_ee_req      = st.ee_req;
  assign o_ee_write    = st.ee_write;
  assign o_ee_addr     = st.ee_addr; // R14
  assign o_ee_wdata    = st.ee_data; // R14
  assign o_ee_preload  = st.ee_preload;

  // checks on the bank's own behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // software write to the ack register, no autoload in the way
  sequence s_ack_wr;
    i_wr && (i_addr == `BVC_OFF_ACK) && !i_al_wr;
  endsequence

  // valid command sitting with start set while idle
  sequence s_ee_armed;
    (st.ee_fsm == bvc_pkg::BVC_EE_IDLE) && st.ee_start &&
    st.ee_cmd[0] != st.ee_cmd[1] && !i_ee_done;
  endsequence

  // engine finishing with no competing software write
  sequence s_ee_finish;
    o_ee_req && i_ee_done && !sw_ee_wr;
  endsequence

  chk_ack_user_wr: assert property ( // R01
    s_ack_wr |=> st.ack_user == $past(i_wdata[`BVC_ACK_MSB:`BVC_ACK_LSB]))
    else $error("ack user value not stored");

  chk_ack_select: assert property ( // R02
    s_ack_wr ##1 !i_al_wr && !(i_wr && i_addr == `BVC_OFF_ACK) |=>
      o_ack_latency == ($past(i_wdata[`BVC_ACK_EN_BIT], 2) ?
                        $past(i_wdata[`BVC_ACK_MSB:`BVC_ACK_LSB], 2) :
                        ACK_DEFAULT))
    else $error("ack latency selection wrong");

  chk_ch0_mode: assert property ( // R03
    i_wr && i_addr == `BVC_OFF_DRV && !i_al_wr |=>
      o_ch0_mode == $past(i_wdata[`BVC_CH0_MSB:`BVC_CH0_LSB]))
    else $error("channel 0 mode not taken");

  chk_ch1_mode: assert property ( // R04
    i_wr && i_addr == `BVC_OFF_DRV && !i_al_wr |=>
      o_ch1_mode == $past(i_wdata[`BVC_CH1_MSB:`BVC_CH1_LSB]))
    else $error("channel 1 mode not taken");

  chk_test_zero: assert property ( // R05
    i_rd && (i_addr == `BVC_OFF_TEST1 || i_addr == `BVC_OFF_TEST2 ||
             i_addr == `BVC_OFF_TEST3) |=> o_rdata == `BVC_ZERO32)
    else $error("test register read not zero");

  chk_strap_track: assert property ( // R07
    !st.strap_locked && !i_al_wr [*4] |->
      st.strap == $past(strap_pins, 3))
    else $error("strap status not following pins");

  chk_strap_upper: assert property ( // R08
    i_rd && i_addr == `BVC_OFF_STRAP |=>
      o_rdata[31:`BVC_STRAP_MSB+1] == '0 &&
      o_rdata[`BVC_STRAP_MSB:0] == $past(st.strap))
    else $error("strap status read wrong");

  chk_gpio_read: assert property ( // R09
    i_rd && i_addr == `BVC_OFF_GPIO |=>
      o_rdata[`BVC_GIN_MSB:`BVC_GIN_LSB] == $past(i_gpio_in, 3))
    else $error("pin level readback wrong");

  chk_gpio_drive: assert property ( // R11
    i_wr && i_addr == `BVC_OFF_GPIO |=>
      o_gpio_oe == $past(i_wdata[`BVC_GDIR_MSB:`BVC_GDIR_LSB]) &&
      o_gpio_out == $past(i_wdata[`BVC_GOUT_MSB:`BVC_GOUT_LSB]))
    else $error("pin direction or value not taken");

  chk_ee_launch: assert property ( // R12
    s_ee_armed |=> o_ee_req &&
      o_ee_write == ($past(st.ee_cmd) == bvc_pkg::BVC_CMD_WRITE))
    else $error("eeprom cycle not launched");

  chk_ee_reserved: assert property ( // R13
    (st.ee_fsm == bvc_pkg::BVC_EE_IDLE) && st.ee_start &&
    st.ee_cmd[0] == st.ee_cmd[1] && !sw_ee_wr |=> !o_ee_req && !st.ee_start)
    else $error("reserved eeprom command issued");

  chk_ee_done: assert property ( // R20
    s_ee_finish |=> !o_ee_req && !st.ee_start)
    else $error("start bit not cleared at completion");

  chk_cap_header: assert property ( // R15
    i_rd && i_addr == `BVC_OFF_CAP |=> o_rdata == 32'h0011_0010)
    else $error("capability header read wrong");

endmodule : bvc_regs
`default_nettype wire

// [tb/bvc_regs_tb.sv]
// Purpose: self-checking bench of the vendor configuration bank
// Assumes: read data stand one cycle after the read strobe only
// Notes:   random fields from a fixed seed, corner cases by hand
`default_nettype none
`include "bvc_defines.svh"

module bvc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // non-zero defaults so that a reset value cannot pass by accident
  localparam logic [13:0] ACK_DEF  = 14'h0155;
  localparam logic [5:0]  PM_DEF   = 6'h2a;
  localparam logic [31:0] CAP_WORD = 32'h0011_0010;
  localparam int          LIMIT    = 20000;
  localparam logic [3:0]  MODES [4] = '{4'h0, 4'h1, 4'hb, 4'hf};
  localparam logic [7:0]  TBL [11] = '{`BVC_OFF_ACK, `BVC_OFF_DRV,
    `BVC_OFF_PM, `BVC_OFF_TEST1, `BVC_OFF_TEST2, `BVC_OFF_TEST3,
    `BVC_OFF_STRAP, `BVC_OFF_GPIO, `BVC_OFF_EE, `BVC_OFF_CAP, 8'h00};

  // design ports
  logic        i_clk      = 1'b0;
  logic        i_srst     = 1'b1;
  logic [7:0]  i_addr     = 8'h00;
  logic [31:0] i_wdata    = 32'h0000_0000;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  logic        i_al_wr    = 1'b0;
  logic [7:0]  i_al_addr  = 8'h00;
  logic [31:0] i_al_data  = 32'h0000_0000;
  logic [13:0] strp       = 14'h0000;
  logic [7:0]  i_gpio_in  = 8'h00;
  logic        i_ee_done  = 1'b0;
  logic [15:0] i_ee_rdata = 16'h0000;
  logic [31:0] o_rdata;
  logic [7:0]  o_gpio_out;
  logic [7:0]  o_gpio_oe;
  logic        o_ee_req;
  logic        o_ee_write;
  logic [10:0] o_ee_addr;
  logic [15:0] o_ee_wdata;
  logic        o_ee_preload;
  logic [13:0] o_ack_latency;
  logic [3:0]  o_ch0_mode;
  logic [3:0]  o_ch1_mode;
  logic [5:0]  o_pm_param;
  // bench bookkeeping
  int          n_fail       = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  logic [31:0] w;
  logic [31:0] d;

  bvc_regs #(.ACK_DEFAULT(ACK_DEF), .PM_RESET(PM_DEF)) bvc_regs_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_al_wr(i_al_wr),
    .i_al_addr(i_al_addr), .i_al_data(i_al_data),
    .i_low_drive_strap(strp[0]), .i_high_drive_strap(strp[1]),
    .i_tx_current_straps(strp[5:2]), .i_tx_deemphasis_straps(strp[9:6]),
    .i_rx_termination_straps(strp[11:10]),
    .i_tx_termination_straps(strp[13:12]),
    .i_gpio_in(i_gpio_in), .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe),
    .o_ee_req(o_ee_req), .o_ee_write(o_ee_write), .o_ee_addr(o_ee_addr),
    .o_ee_wdata(o_ee_wdata), .i_ee_done(i_ee_done),
    .i_ee_rdata(i_ee_rdata), .o_ee_preload(o_ee_preload),
    .o_ack_latency(o_ack_latency), .o_ch0_mode(o_ch0_mode),
    .o_ch1_mode(o_ch1_mode), .o_pm_param(o_pm_param)
  );

  // 125 MHz clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // hang guard, generous against the few hundred cycles needed
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  // value a register holds straight after reset with all pins low
  function automatic logic [31:0] exp_reset(input logic [7:0] a);
    if (a == `BVC_OFF_PM) return {26'h000_0000, PM_DEF};
    if (a == `BVC_OFF_CAP) return CAP_WORD;
    return 32'h0000_0000;
  endfunction : exp_reset

  // effective latency: user value only while its enable is set
  function automatic logic [13:0] exp_ack(input logic [31:0] v);
    return v[30] ? v[29:16] : ACK_DEF;
  endfunction : exp_ack

  // pin control readback: live pins low, stored fields above
  function automatic logic [31:0] exp_gpio(input logic [31:0] v,
                                           input logic [7:0] pins);
    return {8'h00, v[23:8], pins};
  endfunction : exp_gpio

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data are taken in the one cycle where they stand
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic al(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_al_wr   <= 1'b1;
    i_al_addr <= a;
    i_al_data <= v;
    @(posedge i_clk);
    i_al_wr <= 1'b0;
  endtask : al

  // one eeprom operation, engine answers after a short stall
  task automatic ee_op(input logic [1:0] cmd, input logic [15:0] rdv);
    logic [31:0] v;
    logic [31:0] r;
    logic        go;
    v  = {16'($urandom), 11'($urandom), cmd, 1'($urandom), 2'b01};
    go = (cmd == 2'b01) || (cmd == 2'b10);
    wr(`BVC_OFF_EE, v);
    @(posedge i_clk);
    #1 chk(32'(o_ee_req), 32'(go), "ee request");
    chk(32'(o_ee_preload), 32'(v[2]), "ee preload");
    if (go) begin
      chk(32'({o_ee_write, o_ee_addr}), 32'({!cmd[1], v[15:5]}), "ee op");
      chk(32'(o_ee_wdata), 32'(v[31:16]), "ee data");
      rd(`BVC_OFF_EE, r);
      chk(32'(r[0]), 32'h0000_0001, "ee busy");
      repeat (3) @(posedge i_clk);
      i_ee_done  <= 1'b1;
      i_ee_rdata <= rdv;
      @(posedge i_clk);
      i_ee_done <= 1'b0;
      #1 chk(32'(o_ee_req), 32'h0000_0000, "ee release");
      if (!cmd[0]) v[31:16] = rdv;
    end
    rd(`BVC_OFF_EE, r);
    chk(r, {v[31:1], 1'b0}, "ee readback");
  endtask : ee_op

  task automatic final_report;
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    void'($urandom(37800));
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    #1 chk(32'(o_ack_latency), 32'(ACK_DEF), "ack at reset");
    chk(32'({o_gpio_oe, o_ee_req}), 32'h0000_0000, "pins at reset");
    // second pass writes the read-only places and the unmapped one first
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 11; k++) begin
        if (p == 1 && (k inside {3, 4, 5, 6, 9, 10})) wr(TBL[k], $urandom);
        rd(TBL[k], d);
        chk(d, exp_reset(TBL[k]), "reset table");
      end
    end
    // enable clear first, then set
    for (int k = 0; k < 2; k++) begin
      w = {1'b1, k[0], 14'($urandom), 16'h0000};
      wr(`BVC_OFF_ACK, w);
      @(posedge i_clk);
      #1 chk(32'(o_ack_latency), 32'(exp_ack(w)), "ack effective");
      rd(`BVC_OFF_ACK, d);
      chk(d, w & 32'h7fff_ffff, "ack readback");
    end
    // every pairing of the four driver codes
    for (int a = 0; a < 4; a++) begin
      for (int b = 0; b < 4; b++) begin
        w = {24'($urandom), MODES[b], MODES[a]};
        wr(`BVC_OFF_DRV, w);
        #1 chk(32'({o_ch1_mode, o_ch0_mode}), 32'(w[7:0]), "modes");
        rd(`BVC_OFF_DRV, d);
        chk(d, w, "mode readback");
      end
    end
    // write then read with no gap, read data stand one cycle
    w = {24'($urandom), 8'hb1};
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= `BVC_OFF_DRV;
    i_wdata <= w;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, w, "back to back");
    @(posedge i_clk);
    #1 chk(o_rdata, 32'h0000_0000, "read data drop");
    w = $urandom;
    wr(`BVC_OFF_PM, w);
    #1 chk(32'(o_pm_param), 32'(w[5:0]), "pm param");
    // straps tracked live
    repeat (3) begin
      @(posedge i_clk);
      strp <= 14'($urandom);
      repeat (4) @(posedge i_clk);
      rd(`BVC_OFF_STRAP, d);
      chk(d, {18'h0_0000, strp}, "straps");
    end
    // pins: direction, drive and live input level
    repeat (4) begin
      @(posedge i_clk);
      i_gpio_in <= 8'($urandom);
      w = {8'h00, 16'($urandom), 8'h00};
      wr(`BVC_OFF_GPIO, w);
      #1 chk(32'(o_gpio_oe), 32'(w[15:8]), "pin direction");
      chk(32'(o_gpio_out & o_gpio_oe), 32'(w[23:16] & w[15:8]), "pin drive");
      repeat (3) @(posedge i_clk);
      rd(`BVC_OFF_GPIO, d);
      chk(d, exp_gpio(w, i_gpio_in), "pin readback");
    end
    // read first, then reserved codes 11 and 00, then write
    for (int k = 0; k < 4; k++) ee_op(2'(k ^ 2), 16'($urandom));
    // autoload, and autoload against a software write in one cycle
    al(`BVC_OFF_DRV, 32'h0000_00fb);
    #1 chk(32'({o_ch1_mode, o_ch0_mode}), 32'h0000_00fb, "load modes");
    @(posedge i_clk);
    i_wr      <= 1'b1;
    i_addr    <= `BVC_OFF_DRV;
    i_wdata   <= 32'h0000_0000;
    i_al_wr   <= 1'b1;
    i_al_addr <= `BVC_OFF_DRV;
    i_al_data <= 32'h0000_001b;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    i_al_wr <= 1'b0;
    #1 chk(32'({o_ch1_mode, o_ch0_mode}), 32'h0000_001b, "load wins");
    w = {2'b01, 14'($urandom), 16'h0000};
    al(`BVC_OFF_ACK, w);
    @(posedge i_clk);
    #1 chk(32'(o_ack_latency), 32'(exp_ack(w)), "load ack");
    // loaded strap word holds while the pins move
    w = $urandom;
    al(`BVC_OFF_STRAP, w);
    strp <= ~strp;
    repeat (4) @(posedge i_clk);
    rd(`BVC_OFF_STRAP, d);
    chk(d, w & 32'h0000_3fff, "load straps");
    // reset in mid-run restores defaults and live strap tracking
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    #1 chk(32'({o_ch1_mode, o_ch0_mode, o_gpio_oe}), 32'h0000_0000, "rereset");
    chk(32'(o_ack_latency), 32'(ACK_DEF), "rereset ack");
    repeat (4) @(posedge i_clk);
    rd(`BVC_OFF_STRAP, d);
    chk(d, {18'h0_0000, strp}, "straps again");
    final_report();
  end
endmodule : bvc_regs_tb
`default_nettype wire
